// ===== core/emwt_map.vh
/*
 * register offsets, field positions, reset values, access mode codes and phase counter constants
 * for the external memory write timing block.
 * assumes: included by bare name from the core/ design files.
 */
`ifndef EMWT_MAP_VH
`define EMWT_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define EMWT_OFS_BANK_CTL       12'h000
`define EMWT_OFS_SHARED_TIM     12'h004
`define EMWT_OFS_WRITE_TIM      12'h104
`define EMWT_OFS_STATUS         12'h108
`define EMWT_ADDR_W             12

////////////////////////////////////////////////////////////////////////////////
// reset values
`define EMWT_RST_BANK_CTL       32'h00001019
`define EMWT_RST_TIMING         32'h0FFFFFFF
`define EMWT_RD_UNMAPPED        32'h00000000

////////////////////////////////////////////////////////////////////////////////
// bank control fields
`define EMWT_BC_BANK_EN         0
`define EMWT_BC_MUX_EN          1
`define EMWT_BC_TYPE_HI         3
`define EMWT_BC_TYPE_LO         2
`define EMWT_BC_WRITE_EN        12
`define EMWT_BC_EXT_MODE        14
`define EMWT_BC_SYNC_WR         19
`define EMWT_BC_USED_MASK       32'h000FFF7F
`define EMWT_TYPE_PSRAM         2'h1

////////////////////////////////////////////////////////////////////////////////
// timing register fields (shared and write layout alike)
`define EMWT_TM_MODE_HI         29
`define EMWT_TM_MODE_LO         28
`define EMWT_TM_LAT_HI          19
`define EMWT_TM_LAT_LO          16
`define EMWT_TM_DSET_HI         15
`define EMWT_TM_DSET_LO         8
`define EMWT_TM_AHLD_HI         7
`define EMWT_TM_AHLD_LO         4
`define EMWT_TM_ASET_HI         3
`define EMWT_TM_ASET_LO         0
`define EMWT_SHARED_RW_MASK     32'h3FFFFFFF
`define EMWT_WRITE_RW_MASK      32'h300FFFFF

////////////////////////////////////////////////////////////////////////////////
// access modes
`define EMWT_MODE_A             2'h0
`define EMWT_MODE_D             2'h3

////////////////////////////////////////////////////////////////////////////////
// phase counter
`define EMWT_CNT_W              8
`define EMWT_CNT_ZERO           8'h00
`define EMWT_CNT_ONE            8'h01

`endif

// ===== core/emwt_phase_cnt.v
/*
 * down counter that times one write phase: loaded with the field value,
 * it reports the last cycle of a phase that lasts value plus one cycles.
 * assumes: load comes from the state machine on the same clock.
 */
`include "emwt_map.vh"

module emwt_phase_cnt (
    // clock and reset
    input  wire                   core_clk,
    input  wire                   resetn,
    // control
    input  wire                   load,
    input  wire [`EMWT_CNT_W-1:0] value,
    // status
    output wire                   last
);

    reg [`EMWT_CNT_W-1:0] count;

    always @(posedge core_clk) begin
        if (!resetn) begin
            count <= `EMWT_CNT_ZERO;
        end else if (load) begin
            count <= value;
        end else if (count != `EMWT_CNT_ZERO) begin
            count <= count - `EMWT_CNT_ONE;
        end
    end

    // last must not look at load: the sequencer derives load from last
    assign last = (count == `EMWT_CNT_ZERO);

endmodule // emwt_phase_cnt

// ===== core/emwt_write_timing.v
/*
 * write cycle timing for the asynchronous sram/rom/nor region: holds the
 * bank control, shared timing and write timing registers and walks each
 * external write through those of the address setup, address hold and data
 * setup phases that apply to it, then turnaround, timed in core_clk periods.
 * assumes: wr_req and the register port come from logic on core_clk.
 */
// Functional notes
// R1: write timings apply only in extended mode
// R2: mode field 29:28 selects modes A to D
// R3: turnaround period follows every write transaction
// R4: turnaround lasts latency field plus one cycles
// R5: data setup only for asynchronous accesses
// R6: data setup lasts field plus one cycles
// R7: address hold only in mode D or multiplexed
// R8: address hold lasts field plus one cycles
// R9: address setup only for async sram/rom/nor
// R10: address setup lasts field plus one cycles
// R11: software keeps reserved bits at reset value
// R12: bank control bit 14 enables extended mode
// R13: non-extended writes use the shared timings
`include "emwt_map.vh"

module emwt_write_timing (
    // clock and reset
    input  wire                    core_clk,
    input  wire                    resetn,
    // register port
    input  wire [`EMWT_ADDR_W-1:0] reg_addr,
    input  wire [31:0]             reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output reg  [31:0]             reg_rdata,
    // write request from the bus side
    input  wire                    wr_req,
    output reg                     wr_busy,
    output reg                     wr_done,
    output reg                     wr_err,
    // external memory strobes
    output reg                     mem_cs_n,
    output reg                     mem_we_n,
    output reg                     mem_adv,
    output reg  [1:0]              mem_mode
);

    ////////////////////////////////////////////////////////////////////////////
    // states
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ASET = 5'h02;
    localparam [4:0] ST_AHLD = 5'h04;
    localparam [4:0] ST_DSET = 5'h08;
    localparam [4:0] ST_TURN = 5'h10;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    reg [31:0] bank_control_reg;
    reg [31:0] shared_timing;
    reg [31:0] write_timing_config;
    reg [4:0]  state;
    reg [4:0]  next_state;
    reg        cnt_load;
    reg [7:0]  cnt_value;
    wire       cnt_last;

    wire sel_bank   = (reg_addr == `EMWT_OFS_BANK_CTL);
    wire sel_shared = (reg_addr == `EMWT_OFS_SHARED_TIM);
    wire sel_write  = (reg_addr == `EMWT_OFS_WRITE_TIM);
    wire sel_status = (reg_addr == `EMWT_OFS_STATUS);

    // reserved bits are held at their reset value, whatever software writes
    always @(posedge core_clk) begin
        if (!resetn) begin
            bank_control_reg    <= `EMWT_RST_BANK_CTL;
            shared_timing       <= `EMWT_RST_TIMING;
            write_timing_config <= `EMWT_RST_TIMING;
        end else if (reg_wr) begin
            if (sel_bank) begin
                bank_control_reg <= reg_wdata & `EMWT_BC_USED_MASK;
            end
            if (sel_shared) begin
                shared_timing <= (reg_wdata & `EMWT_SHARED_RW_MASK)
                               | (`EMWT_RST_TIMING & ~`EMWT_SHARED_RW_MASK);
            end
            if (sel_write) begin
                write_timing_config <= (reg_wdata & `EMWT_WRITE_RW_MASK)
                                     | (`EMWT_RST_TIMING & ~`EMWT_WRITE_RW_MASK); // [R11]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: data stand in the cycle after the strobe only
    always @(posedge core_clk) begin
        if (!resetn) begin
            reg_rdata <= `EMWT_RD_UNMAPPED;
        end else if (reg_rd) begin
            if (sel_bank) begin
                reg_rdata <= bank_control_reg;
            end else if (sel_shared) begin
                reg_rdata <= shared_timing;
            end else if (sel_write) begin
                reg_rdata <= write_timing_config;
            end else if (sel_status) begin
                reg_rdata <= {27'h0000000, state};
            end else begin
                reg_rdata <= `EMWT_RD_UNMAPPED;
            end
        end else begin
            reg_rdata <= `EMWT_RD_UNMAPPED;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // effective timing selection
    wire ext_mode_enable = bank_control_reg[`EMWT_BC_EXT_MODE]; // [R12]
    wire mux_en          = bank_control_reg[`EMWT_BC_MUX_EN];
    wire sync_wr         = bank_control_reg[`EMWT_BC_SYNC_WR];
    wire [1:0] mem_type  = bank_control_reg[`EMWT_BC_TYPE_HI:`EMWT_BC_TYPE_LO];
    wire bank_ok         = bank_control_reg[`EMWT_BC_BANK_EN]
                         & bank_control_reg[`EMWT_BC_WRITE_EN];

    // outside extended mode the write register is ignored entirely
    wire [31:0] tim = ext_mode_enable ? write_timing_config : shared_timing; // [R1] [R13]

    // mode bits only mean anything in extended mode; otherwise mode A
    wire [1:0] write_access_mode = ext_mode_enable ?
        write_timing_config[`EMWT_TM_MODE_HI:`EMWT_TM_MODE_LO] : `EMWT_MODE_A; // [R2]

    wire [3:0] write_turnaround_latency = tim[`EMWT_TM_LAT_HI:`EMWT_TM_LAT_LO];
    wire [7:0] write_data_setup         = tim[`EMWT_TM_DSET_HI:`EMWT_TM_DSET_LO];
    wire [3:0] write_addr_hold          = tim[`EMWT_TM_AHLD_HI:`EMWT_TM_AHLD_LO];
    wire [3:0] write_addr_setup         = tim[`EMWT_TM_ASET_HI:`EMWT_TM_ASET_LO];

    wire use_aset = !sync_wr && (mem_type != `EMWT_TYPE_PSRAM);        // [R9]
    wire use_ahld = (write_access_mode == `EMWT_MODE_D) || mux_en;     // [R7]
    wire use_dset = !sync_wr;                                          // [R5]

    ////////////////////////////////////////////////////////////////////////////
    // phase sequencer
    // each phase lasts its field value plus one cycles: counter loaded with
    // the raw field on entry and left when it reaches zero
    always @* begin
        next_state = state;
        cnt_load   = 1'b0;
        cnt_value  = `EMWT_CNT_ZERO;
        case (state)
            ST_IDLE: begin
                if (wr_req && bank_ok) begin
                    cnt_load = 1'b1;
                    if (use_aset) begin
                        next_state = ST_ASET;
                        cnt_value  = {4'h0, write_addr_setup};          // [R10]
                    end else if (use_ahld) begin
                        next_state = ST_AHLD;
                        cnt_value  = {4'h0, write_addr_hold};           // [R8]
                    end else if (use_dset) begin
                        next_state = ST_DSET;
                        cnt_value  = write_data_setup;                  // [R6]
                    end else begin
                        // synchronous write: one strobe cycle, no setup
                        next_state = ST_DSET;
                        cnt_value  = `EMWT_CNT_ZERO;
                    end
                end
            end
            ST_ASET: begin
                if (cnt_last) begin
                    cnt_load = 1'b1;
                    if (use_ahld) begin
                        next_state = ST_AHLD;
                        cnt_value  = {4'h0, write_addr_hold};           // [R8]
                    end else begin
                        next_state = ST_DSET;
                        cnt_value  = use_dset ? write_data_setup : `EMWT_CNT_ZERO; // [R6]
                    end
                end
            end
            ST_AHLD: begin
                if (cnt_last) begin
                    cnt_load   = 1'b1;
                    next_state = ST_DSET;
                    cnt_value  = use_dset ? write_data_setup : `EMWT_CNT_ZERO; // [R5]
                end
            end
            ST_DSET: begin
                if (cnt_last) begin
                    cnt_load   = 1'b1;
                    next_state = ST_TURN;                               // [R3]
                    cnt_value  = {4'h0, write_turnaround_latency};      // [R4]
                end
            end
            ST_TURN: begin
                if (cnt_last) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    emwt_phase_cnt u_phase_cnt (
        .core_clk (core_clk),
        .resetn   (resetn),
        .load     (cnt_load),
        .value    (cnt_value),
        .last     (cnt_last)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state and registered outputs
    always @(posedge core_clk) begin
        if (!resetn) begin
            state    <= ST_IDLE;
            wr_busy  <= 1'b0;
            wr_done  <= 1'b0;
            wr_err   <= 1'b0;
            mem_cs_n <= 1'b1;
            mem_we_n <= 1'b1;
            mem_adv  <= 1'b0;
            mem_mode <= `EMWT_MODE_A;
        end else begin
            state    <= next_state;
            wr_busy  <= (next_state != ST_IDLE);
            // done marks the end of turnaround, when a new write is allowed
            wr_done  <= (state == ST_TURN) && (next_state == ST_IDLE);
            // writes to a disabled or write-protected bank are refused
            wr_err   <= (state == ST_IDLE) && wr_req && !bank_ok;
            // chip select released during turnaround so the bus can settle
            mem_cs_n <= !((next_state == ST_ASET) || (next_state == ST_AHLD)
                          || (next_state == ST_DSET));
            mem_we_n <= (next_state != ST_DSET);
            mem_adv  <= (next_state == ST_ASET) && mux_en;
            if ((state == ST_IDLE) && (next_state != ST_IDLE)) begin
                mem_mode <= write_access_mode;                          // [R2]
            end
        end
    end

endmodule // emwt_write_timing

// ===== tb/emwt_write_timing_sva.sv
/*
 * concurrent checks on the write timing block's ports.
 * assumes: bound to emwt_write_timing, single clock core_clk.
 */
module emwt_write_timing_sva (
    // clock and reset
    input wire        core_clk,
    input wire        resetn,
    // register port and sequencer
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    input wire        wr_req,
    input wire        wr_busy,
    input wire        wr_done,
    input wire        wr_err,
    // memory strobes
    input wire        mem_cs_n,
    input wire        mem_we_n,
    input wire        mem_adv
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_turn;
        wr_busy && mem_cs_n;
    endsequence
    a_turn_then_done: assert property (s_turn |-> ##[1:16] wr_done)
        else $error("turnaround overran");
    a_cs_frame_len: assert property ($fell(mem_cs_n) |-> ##[1:290] mem_cs_n)
        else $error("chip select low too long");
    a_dset_bound: assert property ($fell(mem_we_n) |-> ##[1:256] mem_we_n)
        else $error("data phase too long");
    a_we_in_cs: assert property (!mem_we_n |-> !mem_cs_n)
        else $error("write strobe outside select");
    a_adv_in_setup: assert property (mem_adv |-> !mem_cs_n && mem_we_n)
        else $error("adv outside address setup");
    a_idle_quiet: assert property (!wr_busy |-> mem_cs_n && mem_we_n)
        else $error("strobes active while idle");
    a_busy_cause: assert property ($rose(wr_busy) |-> $past(wr_req))
        else $error("busy without request");
    a_done_ends: assert property (wr_done |-> !wr_busy && $past(wr_busy))
        else $error("done without busy end");
    a_err_cause: assert property (wr_err |-> $past(wr_req) && !$past(wr_busy))
        else $error("error without idle request");
    a_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
        else $error("read data outside slot");
endmodule // emwt_write_timing_sva
////////////////////////////////////////////////////////////////////////////////
bind emwt_write_timing emwt_write_timing_sva chk (.core_clk(core_clk), .resetn(resetn),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wr_req(wr_req), .wr_busy(wr_busy),
    .wr_done(wr_done), .wr_err(wr_err), .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n),
    .mem_adv(mem_adv));

// ===== tb/emwt_mem_model.sv
/*
 * external async memory: measures each select frame.
 * assumes: strobes registered on core_clk; reports lengths at frame end.
 */
module emwt_mem_model (
    input  wire core_clk,
    input  wire mem_cs_n,
    input  wire mem_we_n,
    input  wire mem_adv,
    output int  cs_len,
    output int  we_len,
    output int  ad_len
);
    timeunit 1ns;
    timeprecision 1ps;
    int cs_run = 0, we_run = 0, ad_run = 0;
    initial {cs_len, we_len, ad_len} = '0;
    // the chip only sees strobe widths, so that is all it keeps
    always @(posedge core_clk) begin
        if (!mem_cs_n) begin
            cs_run <= cs_run + 1;
            we_run <= we_run + int'(!mem_we_n);
            ad_run <= ad_run + int'(mem_adv);
        end else if (cs_run != 0) begin
            cs_len <= cs_run;
            we_len <= we_run;
            ad_len <= ad_run;
            {cs_run, we_run, ad_run} <= '0;
        end
    end
endmodule // emwt_mem_model

// ===== tb/emwt_write_timing_bench.sv
/*
 * self-checking bench for the write timing block.
 * assumes: design at core/, memory model and checker in tb/.
 */
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module emwt_write_timing_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, wr_req = 0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h00000000;
    wire  [31:0] reg_rdata;
    wire  wr_busy, wr_done, wr_err, mem_cs_n, mem_we_n, mem_adv;
    wire  [1:0] mem_mode;
    int   cs_len, we_len, ad_len, fails = 0, checked = 0;
    always #12.5 core_clk = ~core_clk;
    emwt_write_timing dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .wr_req(wr_req), .wr_busy(wr_busy), .wr_done(wr_done), .wr_err(wr_err),
        .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n), .mem_adv(mem_adv), .mem_mode(mem_mode));
    emwt_mem_model mem (.core_clk(core_clk), .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n),
        .mem_adv(mem_adv), .cs_len(cs_len), .we_len(we_len), .ad_len(ad_len));
    ////////////////////////////////////////////////////////////////////////////
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk) reg_wr <= 1'b0;
    endtask
    task automatic rreg(input logic [11:0] a, input logic [31:0] e);
        @(posedge core_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge core_clk) reg_rd <= 1'b0;
        #1 `CHK("rdata", e, reg_rdata)
    endtask
    // one external write; n counts cycles from request to done
    task automatic run(input logic [1:0] m, input int tot, cs, we, ad);
        int n;
        @(posedge core_clk) wr_req <= 1'b1;
        @(posedge core_clk) wr_req <= 1'b0;
        #1 n = 1;
        `CHK("mode", m, mem_mode)
        while (wr_done !== 1'b1 && n < 400) begin
            @(posedge core_clk) #1 n++;
        end
        `CHK("total", tot, n)
        `CHK("cs_len", cs, cs_len)
        `CHK("we_len", we, we_len)
        `CHK("adv_len", ad, ad_len)
    endtask
    task t_regs;
        rreg(12'h104, 32'h0FFFFFFF);
        rreg(12'h000, 32'h00001019);
        rreg(12'h200, 32'h00000000);
        rreg(12'h108, 32'h00000001);
        wreg(12'h104, 32'h3FF00221);
        rreg(12'h104, 32'h3FF00221);
        $display("test regs done");
    endtask
    task t_ext;
        wreg(12'h000, 32'h00005019);
        wreg(12'h104, 32'h0FF00221);
        run(2'h0, 7, 5, 3, 0);
        wreg(12'h104, 32'h1FFF0221);
        run(2'h1, 22, 5, 3, 0);
        wreg(12'h104, 32'h2FF00221);
        run(2'h2, 7, 5, 3, 0);
        wreg(12'h104, 32'h3FF00221);
        run(2'h3, 10, 8, 3, 0);
        $display("test ext done");
    endtask
    task t_shared;
        wreg(12'h004, 32'h00010113);
        wreg(12'h000, 32'h00001019);
        run(2'h0, 9, 6, 2, 0);
        wreg(12'h000, 32'h0000101B);
        run(2'h0, 11, 8, 2, 4);
        wreg(12'h000, 32'h00081019);
        run(2'h0, 4, 1, 1, 0);
        wreg(12'h000, 32'h00000019);
        @(posedge core_clk) wr_req <= 1'b1;
        @(posedge core_clk) wr_req <= 1'b0;
        #1 `CHK("err", 1'b1, wr_err)
        $display("test shared done");
    endtask
    task stop_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        t_regs;
        t_ext;
        t_shared;
        stop_test;
    end
    // runs well under 300 cycles; a hang stops here
    initial begin
        repeat (3000) @(posedge core_clk);
        fails++;
        stop_test;
    end
endmodule // emwt_write_timing_bench
